/* File: sprg_top.sv */
// sprg_top: serial port rate generator with register port and receive majority vote
// assumes a master that keeps strobes one cycle long and never both at once
`timescale 1ns/1ps
`default_nettype none

// Operation
// - eight-bit divider after reset; wide select uses both divisor bytes
// - free-running timer period set by the high and low divisor bytes
// - high speed select matters only in asynchronous mode
// - rates fosc/64(n+1), fosc/16(n+1), fosc/4(n+1) per mode
// - synchronous rate used only when the port is clock master
// - any divisor byte write clears the timer at once
// - receive pin sampled three times per bit, majority decides level
// - in synchronous mode, clock source select set means master, clear means external clock slave
module sprg_top (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       receive_pin,
  input  wire logic       sample_en,
  output logic            rate_tick,
  output logic            rx_level,
  output logic            sync_master
);
  sprg_pkg::sprg_state_t q, d;

  logic        wide_divider_select;
  logic        high_speed_select;
  logic        clock_source_select;
  logic        sync_mode;
  logic [15:0] divisor;
  logic [5:0]  pre_top;
  logic        div_write;
  logic        mode_write;

  // mode decode
  always_comb begin
    sync_mode           = q.tx_ctrl[sprg_pkg::TX_SYNC_BIT];
    high_speed_select   = q.tx_ctrl[sprg_pkg::TX_HIGH_SPD_BIT];
    clock_source_select = q.tx_ctrl[sprg_pkg::TX_CLK_SRC_BIT];
    wide_divider_select = q.rate_ctrl[sprg_pkg::RATE_WIDE_BIT];
    // high byte ignored unless wide mode selected
    divisor = wide_divider_select ? {q.div_hi, q.div_lo} : {8'h00, q.div_lo};
    if (sync_mode) begin
      pre_top = sprg_pkg::PRE_SYNC;
    end else if (wide_divider_select && high_speed_select) begin
      pre_top = sprg_pkg::PRE_ASYNC_WH;
    end else if (wide_divider_select || high_speed_select) begin
      pre_top = sprg_pkg::PRE_ASYNC_HIGH;
    end else begin
      pre_top = sprg_pkg::PRE_ASYNC_LOW;
    end
    div_write = wr && (addr == sprg_pkg::ADDR_DIV_HI || addr == sprg_pkg::ADDR_DIV_LO);
    // a mode change restarts too, so the prescaler never sits above a lowered top
    mode_write = wr && (addr == sprg_pkg::ADDR_TX_CTRL || addr == sprg_pkg::ADDR_RATE_CTRL);
  end

  // next state: registers, divider chain, sampler
  always_comb begin
    d       = q;
    d.tick  = 1'b0;
    d.rdata = 8'h00;
    if (wr) begin
      case (addr)
        sprg_pkg::ADDR_TX_CTRL:   d.tx_ctrl = (wdata & 8'hfd) | (q.tx_ctrl & 8'h02);
        sprg_pkg::ADDR_RX_CTRL:   d.rx_ctrl = (wdata & 8'hf8) | (q.rx_ctrl & 8'h07);
        sprg_pkg::ADDR_RATE_CTRL: d.rate_ctrl = (wdata & sprg_pkg::RATE_CTRL_WMASK)
                                              | (q.rate_ctrl & 8'h40);
        sprg_pkg::ADDR_DIV_HI:    d.div_hi = wdata;
        sprg_pkg::ADDR_DIV_LO:    d.div_lo = wdata;
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        sprg_pkg::ADDR_TX_CTRL:   d.rdata = q.tx_ctrl;
        sprg_pkg::ADDR_RX_CTRL:   d.rdata = q.rx_ctrl;
        sprg_pkg::ADDR_RATE_CTRL: d.rdata = q.rate_ctrl;
        sprg_pkg::ADDR_DIV_HI:    d.rdata = q.div_hi;
        sprg_pkg::ADDR_DIV_LO:    d.rdata = q.div_lo;
        default:                  d.rdata = 8'h00;
      endcase
    end
    // prescaler then n+1 counter; a divisor or mode write restarts both
    if (div_write || mode_write) begin
      d.pre = 6'h00;
      d.cnt = 16'h0000;
    end else if (q.pre >= pre_top) begin
      d.pre = 6'h00;
      if (q.cnt >= divisor) begin
        d.cnt  = 16'h0000;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end else begin
      d.pre = q.pre + 6'h01;
    end
    // pin synchroniser, first stage feeds only the second
    d.rx_sync = {q.rx_sync[0], receive_pin};
    if (sample_en) begin
      d.smp = {q.smp[1:0], q.rx_sync[1]};
    end
    d.rx_level = (q.smp[0] & q.smp[1]) | (q.smp[1] & q.smp[2]) | (q.smp[0] & q.smp[2]);
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q           <= '0;
      q.tx_ctrl   <= sprg_pkg::TX_CTRL_RST;
      q.rx_ctrl   <= sprg_pkg::RX_CTRL_RST;
      q.rate_ctrl <= sprg_pkg::RATE_CTRL_RST;
      q.div_hi    <= sprg_pkg::DIV_RST;
      q.div_lo    <= sprg_pkg::DIV_RST;
      q.smp       <= 3'h7;
      q.rx_level  <= 1'b1;
      q.rx_sync   <= 2'h3;
    end else begin
      q <= d;
    end
  end

  // outputs: sync slave gets no internal clock, so tick is gated
  logic sync_master_q;
  logic rate_tick_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_master_q <= 1'b0;
      rate_tick_q   <= 1'b0;
    end else begin
      sync_master_q <= sync_mode & clock_source_select;
      rate_tick_q   <= d.tick & ~(sync_mode & ~clock_source_select);
    end
  end
  assign rdata       = q.rdata;
  assign rx_level    = q.rx_level;
  assign rate_tick   = rate_tick_q;
  assign sync_master = sync_master_q;

  // assertions
  property p_clear_on_write;
    @(posedge clock) disable iff (!nrst) div_write |=> (q.cnt == 16'h0000 && q.pre == 6'h00);
  endproperty
  a_clear_on_write: assert property (p_clear_on_write) else $error("timer not cleared");

  property p_narrow_ignores_hi;
    @(posedge clock) disable iff (!nrst) !wide_divider_select |-> divisor[15:8] == 8'h00;
  endproperty
  a_narrow_ignores_hi: assert property (p_narrow_ignores_hi) else $error("high byte used");

  property p_sync_pre;
    @(posedge clock) disable iff (!nrst) sync_mode |-> pre_top == 6'h03;
  endproperty
  a_sync_pre: assert property (p_sync_pre) else $error("sync prescale wrong");

  property p_low_pre;
    @(posedge clock) disable iff (!nrst)
      (!sync_mode && !wide_divider_select && !high_speed_select) |-> pre_top == 6'h3f;
  endproperty
  a_low_pre: assert property (p_low_pre) else $error("low speed prescale wrong");

  property p_wh_pre;
    @(posedge clock) disable iff (!nrst)
      (!sync_mode && wide_divider_select && high_speed_select) |-> pre_top == 6'h03;
  endproperty
  a_wh_pre: assert property (p_wh_pre) else $error("wide high prescale wrong");

  property p_slave_no_tick;
    @(posedge clock) disable iff (!nrst)
      $past(sync_mode && !clock_source_select) |-> !rate_tick;
  endproperty
  a_slave_no_tick: assert property (p_slave_no_tick) else $error("tick in slave mode");

  property p_master_flag;
    @(posedge clock) disable iff (!nrst)
      (sync_mode && clock_source_select) |=> sync_master;
  endproperty
  a_master_flag: assert property (p_master_flag) else $error("master flag missing");

  // two like samples four cycles apart hold two of the three votes
  sequence s_low_sample;
    sample_en && !q.rx_sync[1];
  endsequence
  sequence s_high_sample;
    sample_en && q.rx_sync[1];
  endsequence
  sequence s_sample_gap;
    !sample_en [*3];
  endsequence
  property p_majority;
    @(posedge clock) disable iff (!nrst)
      s_low_sample ##1 s_sample_gap ##1 s_low_sample |=> ##1 !rx_level;
  endproperty
  a_majority: assert property (p_majority) else $error("majority vote wrong");

  property p_tick_period;
    @(posedge clock) disable iff (!nrst)
      (d.tick && q.cnt == 16'h0000) |-> q.pre == pre_top;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick off prescale");

  property p_majority_high;
    @(posedge clock) disable iff (!nrst)
      s_high_sample ##1 s_sample_gap ##1 s_high_sample |=> ##1 rx_level;
  endproperty
  a_majority_high: assert property (p_majority_high) else $error("majority high");

  property p_tick_restart;
    @(posedge clock) disable iff (!nrst) d.tick |=> (q.cnt == 16'h0000 && q.pre == 6'h00);
  endproperty
  a_tick_restart: assert property (p_tick_restart) else $error("timer not restarted");

  property p_tick_single;
    @(posedge clock) disable iff (!nrst) rate_tick |=> !rate_tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too wide");

  property p_high_pre;
    @(posedge clock) disable iff (!nrst)
      (!sync_mode && (wide_divider_select != high_speed_select)) |-> pre_top == 6'h0f;
  endproperty
  a_high_pre: assert property (p_high_pre) else $error("high speed prescale wrong");

  property p_master_off;
    @(posedge clock) disable iff (!nrst)
      !(sync_mode && clock_source_select) |=> !sync_master;
  endproperty
  a_master_off: assert property (p_master_off) else $error("master flag stuck");

  property p_pre_in_range;
    @(posedge clock) disable iff (!nrst) q.pre <= pre_top;
  endproperty
  a_pre_in_range: assert property (p_pre_in_range) else $error("prescaler past its top");
endmodule : sprg_top
`default_nettype wire

/* File: sprg_pkg.sv */
// sprg_pkg: register map, field positions and mode constants of the rate generator
// assumes one system clock; no surrounding bus fabric
package sprg_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_TX_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_RX_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_RATE_CTRL = 3'h2;
  localparam logic [2:0] ADDR_DIV_HI    = 3'h3;
  localparam logic [2:0] ADDR_DIV_LO    = 3'h4;
  // field positions
  localparam int TX_CLK_SRC_BIT  = 7;
  localparam int TX_SYNC_BIT     = 4;
  localparam int TX_HIGH_SPD_BIT = 2;
  localparam int RATE_WIDE_BIT   = 3;
  localparam int RX_PORT_EN_BIT  = 7;
  // reset values and masks
  localparam logic [7:0] TX_CTRL_RST   = 8'h02;
  localparam logic [7:0] RX_CTRL_RST   = 8'h00;
  localparam logic [7:0] RATE_CTRL_RST = 8'h40;
  localparam logic [7:0] RATE_CTRL_WMASK = 8'h1b;
  localparam logic [7:0] DIV_RST       = 8'h00;
  // prescale factors
  localparam logic [5:0] PRE_ASYNC_LOW  = 6'h3f;
  localparam logic [5:0] PRE_ASYNC_HIGH = 6'h0f;
  localparam logic [5:0] PRE_SYNC       = 6'h03;
  localparam logic [5:0] PRE_ASYNC_WH   = 6'h03;
  // receive sampling: three samples per bit
  localparam int SAMPLES_PER_BIT = 3;

  typedef struct packed {
    logic [7:0]  tx_ctrl;
    logic [7:0]  rx_ctrl;
    logic [7:0]  rate_ctrl;
    logic [7:0]  div_hi;
    logic [7:0]  div_lo;
    logic [15:0] cnt;
    logic [5:0]  pre;
    logic        tick;
    logic [7:0]  rdata;
    logic [1:0]  rx_sync;
    logic [2:0]  smp;
    logic        rx_level;
  } sprg_state_t;
endpackage : sprg_pkg

/* File: sprg_shift_model.sv */
// sprg_shift_model: stand-in for the shift logic beside the rate generator
// assumes the generator's clock and its active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module sprg_shift_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        rate_tick,
  output logic             sample_en,
  output logic      [15:0] tick_count
);
  logic [1:0] div_q;
  // one sample every fourth cycle, so a four-cycle glitch meets one sample only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_q      <= 2'h0;
      sample_en  <= 1'b0;
      tick_count <= 16'h0000;
    end else begin
      div_q      <= div_q + 2'h1;
      sample_en  <= (div_q == 2'h3);
      tick_count <= tick_count + {15'h0000, rate_tick};
    end
  end
endmodule : sprg_shift_model
`default_nettype wire

/* File: sprg_top_tb.sv */
// sprg_top_tb: self-checking bench for the rate generator
// assumes sprg_pkg and sprg_shift_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module sprg_top_tb;
  logic        clock       = 1'b0;
  logic        nrst        = 1'b0;
  logic [2:0]  addr        = 3'h0;
  logic [7:0]  wdata       = 8'h00;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic        receive_pin = 1'b1;
  logic [7:0]  rdata;
  logic        rate_tick, rx_level, sync_master, sample_en;
  logic [15:0] tick_count;
  int          errors      = 0;
  int          check_count = 0;
  int          cycles      = 0;
  always #2.5 clock = ~clock;
  sprg_top dut (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .receive_pin,
    .sample_en, .rate_tick, .rx_level, .sync_master);
  sprg_shift_model partner (.clock, .nrst, .rate_tick, .sample_en, .tick_count);
  task automatic test_done();
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // hang guard, well above the longest mode sweep
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // bounded wait; counts edges until a tick is seen
  task automatic wait_tick(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rate_tick !== 1'b1 && n < lim);
  endtask : wait_tick
  function automatic logic [7:0] rst_val(input int a);
    case (a)
      0: return sprg_pkg::TX_CTRL_RST;
      1: return sprg_pkg::RX_CTRL_RST;
      2: return sprg_pkg::RATE_CTRL_RST;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  // sync ignores high speed; wide plus high is the fastest async case
  function automatic int period(input logic s, input logic w, input logic h, input int n);
    if (s || (w && h)) return 4 * (n + 1);
    if (w || h) return 16 * (n + 1);
    return 64 * (n + 1);
  endfunction : period
  // main sequence
  initial begin
    int         p, n1, n2, hi, lo;
    logic [7:0] d;
    void'($urandom(40));
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0], d);
      chk({8'h00, d}, {8'h00, rst_val(a)});
    end
    wr_reg(3'h5, 8'hff);
    rd_reg(3'h5, d);
    chk({8'h00, d}, 16'h0000);
    // every mode combination; hi byte random so 8-bit modes must ignore it
    for (int m = 0; m < 8; m++) begin
      hi = $urandom % 2;
      lo = (m == 7) ? 255 : $urandom % 8;
      wr_reg(sprg_pkg::ADDR_TX_CTRL, {m[2], 2'b00, m[2], 1'b0, m[0], 2'b00});
      wr_reg(sprg_pkg::ADDR_RATE_CTRL, {4'h0, m[1], 3'h0});
      wr_reg(sprg_pkg::ADDR_DIV_HI, hi[7:0]);
      wr_reg(sprg_pkg::ADDR_DIV_LO, lo[7:0]);
      p = period(m[2], m[1], m[0], m[1] ? hi * 256 + lo : lo);
      wait_tick(p + 3, n1);
      // the write restarts the timer: first tick one output flop after a full period
      chk(16'(n1), 16'(p + 1));
      wait_tick(p + 1, n2);
      chk(16'(n2), 16'(p));
      chk({15'h0000, sync_master}, {15'h0000, m[2]});
      rd_reg(sprg_pkg::ADDR_DIV_LO, d);
      chk({8'h00, d}, {8'h00, lo[7:0]});
    end
    wr_reg(sprg_pkg::ADDR_TX_CTRL, 8'h10);
    wr_reg(sprg_pkg::ADDR_DIV_HI, 8'h00);
    wr_reg(sprg_pkg::ADDR_DIV_LO, 8'h00);
    n1 = tick_count;
    repeat (300) @(posedge clock);
    chk(tick_count, 16'(n1));
    chk({15'h0000, sync_master}, 16'h0000);
    receive_pin <= 1'b0;
    repeat (20) @(posedge clock);
    // a one-sample glitch must be outvoted
    // drive on the edge, look once the edge has settled
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      receive_pin <= (i < 4);
      #1;
      chk({15'h0000, rx_level}, 16'h0000);
    end
    @(posedge clock);
    receive_pin <= 1'b1;
    repeat (20) @(posedge clock);
    chk({15'h0000, rx_level}, 16'h0001);
    test_done();
  end
endmodule : sprg_top_tb
`default_nettype wire
